// ### mabp_params.svh
`ifndef MABP_PARAMS_SVH
`define MABP_PARAMS_SVH

// ************************************************************
// block geometry
// ************************************************************
`define MABP_WORD_W 24
`define MABP_BLOCK_WORDS 2048
`define MABP_LAST_WORD 11'h7ff
`define MABP_SESS_HDR_WORDS 8
`define MABP_LAST_SESS_WORD 3'h7
`define MABP_CHAN_HDR_WORDS 5
`define MABP_LAST_CHAN_HDR 3'h4
`define MABP_NUM_CH 4
`define MABP_CH_DEPTH 64
`define MABP_FILL_WORD 24'hffffff

// ************************************************************
// header field values
// ************************************************************
`define MABP_SYNC_LOW 24'h36e19c
`define MABP_SYNC_HIGH 5'h09
`define MABP_BLK_CNT_RST 24'h000000
// format version, value is arbitrary
`define MABP_VERSION 6'h01

`endif

// ### mabp_pkg.sv
package mabp_pkg;

    typedef enum logic [4:0] {
        MABP_IDLE = 5'b00001,
        MABP_SESS = 5'b00010,
        MABP_CHDR = 5'b00100,
        MABP_DATA = 5'b01000,
        MABP_FILL = 5'b10000
    } mabp_state_t;

    typedef logic [23:0] mabp_word_t;

    // width code to sample bits: low codes step by one, high codes by two
    function automatic logic [4:0] mabp_width_bits(input logic [3:0] code);
        logic [4:0] c;
        c = {1'b0, code};
        if (code <= 4'h7) begin
            mabp_width_bits = c + 5'h01;
        end else begin
            mabp_width_bits = (c << 1) - 5'h06;
        end
    endfunction

    // lowest-numbered active channel at or above start, with a found flag
    function automatic logic [2:0] mabp_next_active(input logic [3:0] mask, input logic [2:0] start);
        logic [2:0] res;
        res = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= start)) begin
                res = {1'b1, 2'(i)};
            end
        end
        mabp_next_active = res;
    endfunction

endpackage

// ### mabp_chan_if.sv
`timescale 1ns/1ps
interface mabp_chan_if;
    logic swap;
    logic smp_valid;
    logic [23:0] smp_data;
    logic [3:0] width_code;
    logic [5:0] rd_addr;
    logic [23:0] rd_word;
    logic [6:0] word_cnt;
    logic [4:0] left_bits;
    logic [15:0] smp_cnt;

    modport packer (
        input swap, smp_valid, smp_data, width_code, rd_addr,
        output rd_word, word_cnt, left_bits, smp_cnt
    );
    modport framer (
        output swap, smp_valid, smp_data, width_code, rd_addr,
        input rd_word, word_cnt, left_bits, smp_cnt
    );
endinterface

// ### mabp_chan_packer.sv
`timescale 1ns/1ps
`include "mabp_params.svh"
module mabp_chan_packer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    mabp_chan_if.packer ch
);
    import mabp_pkg::*;

    // ************************************************************
    // two banks: one fills with samples, the other is read out
    // ************************************************************
    logic [23:0] mem_q [2][`MABP_CH_DEPTH];
    logic fill_q, fill_d;
    logic [23:0] acc_q, acc_d;
    logic [4:0] used_q, used_d;
    logic [6:0] wcnt_q, wcnt_d;
    logic [15:0] scnt_q, scnt_d;
    logic [6:0] out_wcnt_q, out_wcnt_d;
    logic [4:0] out_left_q, out_left_d;
    logic [15:0] out_scnt_q, out_scnt_d;
    logic wr_en;
    logic [5:0] wr_addr;
    logic [23:0] wr_data;
    logic [4:0] w;
    logic [5:0] sum;
    logic [23:0] masked;
    logic [47:0] merged;

    always_comb begin
        fill_d = fill_q;
        acc_d = acc_q;
        used_d = used_q;
        wcnt_d = wcnt_q;
        scnt_d = scnt_q;
        out_wcnt_d = out_wcnt_q;
        out_left_d = out_left_q;
        out_scnt_d = out_scnt_q;
        wr_en = 1'b0;
        wr_addr = wcnt_q[5:0];
        wr_data = acc_q;
        w = mabp_width_bits(ch.width_code);
        sum = {1'b0, used_q} + {1'b0, w};
        masked = ch.smp_data & (24'hffffff >> (5'd24 - w));
        merged = {acc_q, 24'h000000} | ({24'h000000, masked} << (6'd48 - sum));
        if (ch.swap) begin
            // a sample arriving with the swap is dropped: the bank is closing
            wr_en = (used_q != 5'h00);
            out_wcnt_d = wcnt_q + {6'h00, wr_en};
            out_left_d = used_q;
            out_scnt_d = scnt_q;
            fill_d = ~fill_q;
            acc_d = 24'h000000;
            used_d = 5'h00;
            wcnt_d = 7'h00;
            scnt_d = 16'h0000;
        end else if (ch.smp_valid && (wcnt_q < 7'(`MABP_CH_DEPTH - 1))) begin
            scnt_d = scnt_q + 16'h0001;
            if (sum >= 6'd24) begin
                wr_en = 1'b1;
                wr_data = merged[47:24];
                acc_d = merged[23:0];
                used_d = 5'(sum - 6'd24);
                wcnt_d = wcnt_q + 7'h01;
            end else begin
                acc_d = merged[47:24];
                used_d = sum[4:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            fill_q <= 1'b0;
            acc_q <= 24'h000000;
            used_q <= 5'h00;
            wcnt_q <= 7'h00;
            scnt_q <= 16'h0000;
            out_wcnt_q <= 7'h00;
            out_left_q <= 5'h00;
            out_scnt_q <= 16'h0000;
        end else begin
            fill_q <= fill_d;
            acc_q <= acc_d;
            used_q <= used_d;
            wcnt_q <= wcnt_d;
            scnt_q <= scnt_d;
            out_wcnt_q <= out_wcnt_d;
            out_left_q <= out_left_d;
            out_scnt_q <= out_scnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem_q[fill_q][wr_addr] <= wr_data;
        end
    end

    assign ch.rd_word = mem_q[~fill_q][ch.rd_addr];
    assign ch.word_cnt = out_wcnt_q;
    assign ch.left_bits = out_left_q;
    assign ch.smp_cnt = out_scnt_q;
endmodule

// ### mabp_block_packer.sv
`timescale 1ns/1ps
`include "mabp_params.svh"
// What this block does
// - every block opens with the eight session header words
// - channel packets follow in priority order, channel 0 first
// - all-ones fill words pad the block to 2048 words
// - each packet has five header words, one holding leftover bits, then data
// - data leaves last-in-first-out, earliest samples in the final word
// - first sample fills the top bits, later samples the next lower bits
// - split sample: upper bits low in first word, lower bits high in next
// - reversed output puts the upper-bits word right after the lower-bits word
// - 29-bit sync pattern sits in header words zero and one
// - 24-bit block counter clears at session start, counts each block, wraps
// - active channel count minus one at bits 22 to 19 of word six
// - sample width follows the channel's 4-bit width code
module mabp_block_packer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic session_start_i,
    input wire logic word_strobe_i,
    input wire logic [`MABP_NUM_CH-1:0] chan_active_i,
    input wire logic [`MABP_NUM_CH-1:0] smp_valid_i,
    input wire logic [`MABP_NUM_CH-1:0][23:0] smp_data_i,
    input wire logic [`MABP_NUM_CH-1:0][3:0] sample_width_code_i,
    input wire logic [18:0] master_clk_i,
    input wire logic [23:0] date_code_i,
    input wire logic [23:0] time_code_i,
    input wire logic [23:0] marker_div_i,
    input wire logic clk_src_int_i,
    input wire logic [16:0] start_time_i,
    input wire logic [7:0] user_field_i,
    output logic [23:0] block_word_o,
    output logic word_valid_o,
    output logic block_first_o
);
    import mabp_pkg::*;

    // ************************************************************
    // channel packers
    // ************************************************************
    mabp_chan_if ch_if [`MABP_NUM_CH] ();
    logic swap;
    logic [5:0] rd_addr;
    logic [23:0] rd_word_a [`MABP_NUM_CH];
    logic [6:0] wcnt_a [`MABP_NUM_CH];
    logic [4:0] left_a [`MABP_NUM_CH];
    logic [15:0] scnt_a [`MABP_NUM_CH];

    for (genvar g = 0; g < `MABP_NUM_CH; g++) begin : g_ch
        assign ch_if[g].swap = swap;
        assign ch_if[g].smp_valid = smp_valid_i[g];
        assign ch_if[g].smp_data = smp_data_i[g];
        assign ch_if[g].width_code = sample_width_code_i[g];
        assign ch_if[g].rd_addr = rd_addr;
        assign rd_word_a[g] = ch_if[g].rd_word;
        assign wcnt_a[g] = ch_if[g].word_cnt;
        assign left_a[g] = ch_if[g].left_bits;
        assign scnt_a[g] = ch_if[g].smp_cnt;
        mabp_chan_packer u_packer (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i | session_start_i),
            .ch(ch_if[g].packer)
        );
    end

    // ************************************************************
    // block sequencer
    // ************************************************************
    mabp_state_t st_q, st_d;
    logic [10:0] widx_q, widx_d;
    logic [6:0] pidx_q, pidx_d;
    logic [1:0] ch_q, ch_d;
    logic [3:0] active_q, active_d;
    logic [23:0] blk_cnt_q, blk_cnt_d;
    logic [23:0] word_q, word_d;
    logic valid_q, valid_d;
    logic first_q, first_d;
    logic [2:0] nxt;
    logic [2:0] q_cnt;
    logic [6:0] cur_wcnt;

    always_comb begin
        st_d = st_q;
        widx_d = widx_q;
        pidx_d = pidx_q;
        ch_d = ch_q;
        active_d = active_q;
        blk_cnt_d = blk_cnt_q;
        word_d = word_q;
        valid_d = 1'b0;
        first_d = 1'b0;
        swap = 1'b0;
        cur_wcnt = wcnt_a[ch_q];
        rd_addr = 6'(cur_wcnt - 7'h01 - pidx_q);
        nxt = mabp_next_active(active_q, {1'b0, ch_q} + 3'h1);
        q_cnt = 3'h0;
        for (int i = 0; i < `MABP_NUM_CH; i++) begin
            q_cnt = q_cnt + {2'h0, active_q[i]};
        end
        if (session_start_i) begin
            st_d = MABP_SESS;
            widx_d = 11'h000;
            blk_cnt_d = `MABP_BLK_CNT_RST;
        end else if (word_strobe_i && (st_q != MABP_IDLE)) begin
            valid_d = 1'b1;
            widx_d = widx_q + 11'h001;
            case (st_q)
                MABP_SESS: begin
                    if (widx_q == 11'h000) begin
                        swap = 1'b1;
                        active_d = chan_active_i;
                        first_d = 1'b1;
                    end
                    case (widx_q[2:0])
                        3'h0: word_d = `MABP_SYNC_LOW;
                        3'h1: word_d = {`MABP_SYNC_HIGH, master_clk_i};
                        3'h2: word_d = blk_cnt_q;
                        3'h3: word_d = date_code_i;
                        3'h4: word_d = time_code_i;
                        3'h5: word_d = marker_div_i;
                        // channels minus one; an empty mask wraps to all ones
                        // widened before the subtraction so the wrap lands in four bits, not three
                        3'h6: word_d = {clk_src_int_i, {1'b0, q_cnt} - 4'h1, 2'h0, start_time_i};
                        default: word_d = {user_field_i, 10'h000, `MABP_VERSION};
                    endcase
                    if (widx_q[2:0] == `MABP_LAST_SESS_WORD) begin
                        nxt = mabp_next_active(active_q, 3'h0);
                        st_d = nxt[2] ? MABP_CHDR : MABP_FILL;
                        ch_d = nxt[1:0];
                        pidx_d = 7'h00;
                    end
                end
                MABP_CHDR: begin
                    case (pidx_q[2:0])
                        3'h0: word_d = {2'h0, ch_q, sample_width_code_i[ch_q], 16'h0000};
                        3'h1: word_d = {19'h00000, left_a[ch_q]};
                        3'h2: word_d = {17'h00000, cur_wcnt};
                        3'h3: word_d = {8'h00, scnt_a[ch_q]};
                        default: word_d = 24'h000000;
                    endcase
                    pidx_d = pidx_q + 7'h01;
                    if (pidx_q[2:0] == `MABP_LAST_CHAN_HDR) begin
                        pidx_d = 7'h00;
                        if (cur_wcnt != 7'h00) begin
                            st_d = MABP_DATA;
                        end else begin
                            st_d = nxt[2] ? MABP_CHDR : MABP_FILL;
                            ch_d = nxt[1:0];
                        end
                    end
                end
                MABP_DATA: begin
                    // reversed order puts upper bits after lower
                    word_d = rd_word_a[ch_q];
                    pidx_d = pidx_q + 7'h01;
                    if (pidx_q == cur_wcnt - 7'h01) begin
                        pidx_d = 7'h00;
                        st_d = nxt[2] ? MABP_CHDR : MABP_FILL;
                        ch_d = nxt[1:0];
                    end
                end
                MABP_FILL: begin
                    word_d = `MABP_FILL_WORD;
                end
                default: begin
                    st_d = MABP_IDLE;
                end
            endcase
            if (widx_q == `MABP_LAST_WORD) begin
                st_d = MABP_SESS;
                widx_d = 11'h000;
                blk_cnt_d = blk_cnt_q + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= MABP_IDLE;
            widx_q <= 11'h000;
            pidx_q <= 7'h00;
            ch_q <= 2'h0;
            active_q <= 4'h0;
            blk_cnt_q <= `MABP_BLK_CNT_RST;
            word_q <= 24'h000000;
            valid_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            st_q <= st_d;
            widx_q <= widx_d;
            pidx_q <= pidx_d;
            ch_q <= ch_d;
            active_q <= active_d;
            blk_cnt_q <= blk_cnt_d;
            word_q <= word_d;
            valid_q <= valid_d;
            first_q <= first_d;
        end
    end

    // ************************************************************
    // outputs, all straight from flip-flops
    // ************************************************************
    assign block_word_o = word_q;
    assign word_valid_o = valid_q;
    assign block_first_o = first_q;
endmodule

// ### mabp_block_packer_properties.sv
`timescale 1ns/1ps
`include "mabp_params.svh"
// ************************************************************
// stream checks at the packer's ports
// ************************************************************
module mabp_block_packer_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic session_start_i,
    input wire logic word_strobe_i,
    input wire logic [`MABP_NUM_CH-1:0] chan_active_i,
    input wire logic [23:0] block_word_o,
    input wire logic word_valid_o,
    input wire logic block_first_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic run_q, fresh_q;
    logic [10:0] widx_q;
    logic [23:0] blk_q;
    logic [3:0] act_q, mask_q;

    // the mask is taken at the strobe that emits word 0, one cycle before block_first_o
    always_ff @(posedge clk_i) begin
        act_q <= chan_active_i;
        if (sys_rst_i) begin
            run_q <= 1'b0;
            widx_q <= 11'h0;
        end else if (session_start_i) begin
            run_q <= 1'b1;
            widx_q <= 11'h0;
            fresh_q <= 1'b1;
            blk_q <= 24'h0;
        end else begin
            if (word_valid_o) widx_q <= widx_q + 11'h1;
            if (block_first_o) begin
                fresh_q <= 1'b0;
                blk_q <= fresh_q ? blk_q : blk_q + 24'h1;
                mask_q <= act_q;
            end
        end
    end

    sequence s_taken;
        word_strobe_i && !session_start_i && run_q;
    endsequence
    sequence s_word(int n);
        word_valid_o && widx_q == n;
    endsequence

    chk_valid_follows_strobe: assert property (s_taken |=> word_valid_o)
        else $error("strobe taken without a word one cycle later");
    chk_valid_has_cause: assert property (word_valid_o |-> $past(word_strobe_i) && !$past(session_start_i))
        else $error("word emitted without a taken strobe");
    chk_first_at_start: assert property (word_valid_o |-> block_first_o == (widx_q == 11'h0))
        else $error("block start marker not on word 0 of 2048");
    chk_first_is_sync: assert property (block_first_o |-> word_valid_o && block_word_o == `MABP_SYNC_LOW)
        else $error("word 0 is not the low sync pattern");
    chk_sync_high_bits: assert property (s_word(1) |-> block_word_o[23:19] == 5'h09)
        else $error("word 1 upper sync bits wrong");
    chk_block_count: assert property (s_word(2) |-> block_word_o == blk_q)
        else $error("block counter word wrong");
    chk_active_count: assert property (s_word(6) |-> block_word_o[22:17] == {4'($countones(mask_q) - 1), 2'b00})
        else $error("active channel field wrong");
    chk_word7_spare: assert property (s_word(7) |-> block_word_o[15:0] == {10'h0, `MABP_VERSION})
        else $error("word 7 spare or version wrong");
    chk_fill_tail: assert property (s_word(2047) |-> block_word_o == `MABP_FILL_WORD)
        else $error("last block word is not fill");
    chk_word_holds: assert property (!word_valid_o && !$past(session_start_i) |-> $stable(block_word_o))
        else $error("block word changed without a new word");
endmodule

// ### mabp_recorder_model.sv
`timescale 1ns/1ps
// ************************************************************
// recorder taking block words, two blocks kept by parity
// ************************************************************
module mabp_recorder_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic slow_i,
    input wire logic [23:0] word_i,
    input wire logic valid_i,
    input wire logic first_i,
    output logic strobe_o
);
    logic [23:0] mem [0:1][0:2047];
    logic ph = 1'b0;
    int idx = 0;
    int blocks = 0;
    int nwords = 0;

    initial strobe_o = 1'b0;

    // a slow recorder strobes only every other cycle
    always @(negedge clk_i) begin
        ph <= ~ph;
        strobe_o <= run_i && (!slow_i || ph);
    end

    always @(posedge clk_i) begin
        if (valid_i) begin
            if (first_i) begin
                blocks = blocks + 1;
                idx = 0;
            end
            if (idx < 2048) mem[blocks % 2][idx] = word_i;
            idx = idx + 1;
            nwords = nwords + 1;
        end
    end
endmodule

// ### multichannel_audio_block_packer_tb.sv
`timescale 1ns/1ps
module multichannel_audio_block_packer_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic session_start_i = 1'b0;
    logic word_strobe_i, word_valid_o, block_first_o;
    logic rec_run = 1'b0;
    logic rec_slow = 1'b0;
    logic src = 1'b1;
    logic [3:0] chan_active_i = 4'hd;
    logic [3:0] smp_valid_i = 4'h0;
    logic [3:0][23:0] smp_data_i = '0;
    logic [3:0][3:0] wcode = {4'hb, 4'hf, 4'h3, 4'h7};
    logic [18:0] mc = 19'h2a5a5;
    logic [23:0] date = 24'h040512;
    logic [23:0] tod = 24'h123456;
    logic [23:0] bmd = 24'h000400;
    logic [16:0] sst = 17'h1abcd;
    logic [7:0] user = 8'h5c;
    logic [23:0] block_word_o;
    logic [23:0] exp_w [0:27];
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    mabp_block_packer dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .session_start_i(session_start_i), .word_strobe_i(word_strobe_i),
        .chan_active_i(chan_active_i), .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
        .sample_width_code_i(wcode), .master_clk_i(mc), .date_code_i(date), .time_code_i(tod),
        .marker_div_i(bmd), .clk_src_int_i(src), .start_time_i(sst), .user_field_i(user),
        .block_word_o(block_word_o), .word_valid_o(word_valid_o), .block_first_o(block_first_o)
    );
    mabp_recorder_model rec (
        .clk_i(clk_i), .run_i(rec_run), .slow_i(rec_slow), .word_i(block_word_o),
        .valid_i(word_valid_o), .first_i(block_first_o), .strobe_o(word_strobe_i)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_done(input int n);
        while (!(rec.blocks > n || (rec.blocks == n && rec.idx == 2048))) @(negedge clk_i);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_refuse();
        rec_run = 1'b1;
        repeat (20) @(negedge clk_i);
        chk("words before start", 24'h0, 24'(rec.nwords));
        $display("test refuse done");
    endtask

    // 8-bit, 24-bit and 16-bit (split) channels; channel 1 inactive
    task automatic t_block();
        logic [3:0][23:0] sd [0:3];
        logic [3:0] vm [0:3];
        sd = '{{24'h1234, 24'h0a0b0c, 24'h55, 24'h11}, {24'h5678, 48'h0, 24'h22}, {72'h0, 24'h33}, {72'h0, 24'h44}};
        vm = '{4'hf, 4'h9, 4'h1, 4'h1};
        exp_w = '{24'h36e19c, {5'h09, mc}, 24'h1, date, tod, bmd, {src, 4'h2, 2'b00, sst}, {user, 10'h0, 6'h01},
            24'h070000, 24'h8, 24'h2, 24'h4, 24'h0, 24'h440000, 24'h112233,
            24'h2f0000, 24'h0, 24'h1, 24'h1, 24'h0, 24'h0a0b0c,
            24'h3b0000, 24'h8, 24'h2, 24'h2, 24'h0, 24'h780000, 24'h123456};
        session_start_i = 1'b1;
        @(negedge clk_i);
        session_start_i = 1'b0;
        while (!(rec.blocks == 1 && rec.idx > 8)) @(negedge clk_i);
        for (int s = 0; s < 4; s++) begin
            smp_valid_i = vm[s];
            smp_data_i = sd[s];
            @(negedge clk_i);
        end
        smp_valid_i = 4'h0;
        wait_done(2);
        chk("first block packet length", 24'h0, rec.mem[1][10]);
        for (int i = 0; i < 8; i++) chk($sformatf("header word %0d", i), exp_w[i], rec.mem[0][i]);
        for (int i = 8; i < 28; i++) chk($sformatf("packet word %0d", i), exp_w[i], rec.mem[0][i]);
        for (int i = 28; i < 2048; i++) chk($sformatf("fill word %0d", i), 24'hffffff, rec.mem[0][i]);
        $display("test block done");
    endtask

    // restart mid-block with a slow recorder and no active channels
    task automatic t_restart();
        int nb;
        logic [23:0] hv [0:8];
        while (rec.blocks < 3 || rec.idx < 100) @(negedge clk_i);
        {mc, date, tod, bmd, sst, user, src} = {19'h01234, 24'h991231, 24'h235959, 24'h0000ff, 17'h00042, 8'ha3, 1'b0};
        rec_slow = 1'b1;
        chan_active_i = 4'h0;
        session_start_i = 1'b1;
        @(negedge clk_i);
        session_start_i = 1'b0;
        nb = rec.blocks + 1;
        hv = '{24'h36e19c, {5'h09, mc}, 24'h0, date, tod, bmd, {src, 4'hf, 2'b00, sst}, {user, 10'h0, 6'h01}, 24'hffffff};
        wait_done(nb);
        for (int i = 0; i < 9; i++) chk($sformatf("restart word %0d", i), hv[i], rec.mem[nb % 2][i]);
        $display("test restart done");
    endtask

    always #4 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("[ERR] run time expected below 20000 seen 20000");
            conclude();
        end
    end

    initial begin
        repeat (20) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_refuse();
        t_block();
        t_restart();
        conclude();
    end
endmodule

bind mabp_block_packer mabp_block_packer_properties chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .session_start_i(session_start_i), .word_strobe_i(word_strobe_i), .chan_active_i(chan_active_i),
    .block_word_o(block_word_o), .word_valid_o(word_valid_o), .block_first_o(block_first_o));
